// ---- scp_dev.sv ----
// The APB slave port and the address map were decided locally.
module scp_dev (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    scp_if.dev               link,
    input  wire logic [2:0]  strap_addr,
    output logic      [1:0]  feedback_cap_code,
    output logic      [1:0]  conversion_time_code,
    output logic      [3:0]  post_gain_code,
    output logic             analog_out_en
);
    logic                  fe_m;
    logic                  fe_q;
    logic                  fe_d;
    logic                  ck_m;
    logic                  ck_q;
    logic                  ck_d;
    logic                  oc_m;
    logic                  oc_q;
    logic                  dt_m;
    logic                  dt_q;
    logic [2:0]            st_m;
    logic [2:0]            st_q;
    logic                  fe_rise;
    logic                  fe_fall;
    logic                  ck_rise;
    logic                  ck_fall;
    logic [4:0]            pulses;
    logic [15:0]           shift_in;
    logic [7:0]            adj_code;
    logic [7:0]            shift_out;
    logic                  long_match;
    logic                  short_match;
    logic                  read_match;
    scp_pkg::scp_dev_state_e state;

    // Two-stage synchronisers
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fe_m <= 1'b0;
            fe_q <= 1'b0;
            ck_m <= 1'b0;
            ck_q <= 1'b0;
            oc_m <= 1'b0;
            oc_q <= 1'b0;
            dt_m <= 1'b0;
            dt_q <= 1'b0;
            st_m <= 3'h0;
            st_q <= 3'h0;
        end
        else
        begin
            fe_m <= link.frame_enable;
            fe_q <= fe_m;
            ck_m <= link.sclk;
            ck_q <= ck_m;
            oc_m <= link.out_ctrl;
            oc_q <= oc_m;
            dt_m <= link.data_line;
            dt_q <= dt_m;
            st_m <= strap_addr;
            st_q <= st_m;
        end
    end

    // Edge history
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fe_d <= 1'b0;
            ck_d <= 1'b0;
        end
        else
        begin
            fe_d <= fe_q;
            ck_d <= ck_q;
        end
    end

    assign fe_rise = fe_q & ~fe_d;
    assign fe_fall = ~fe_q & fe_d;
    assign ck_rise = ck_q & ~ck_d & fe_q;
    assign ck_fall = ~ck_q & ck_d & fe_q;

    // Address decode per frame shape
    assign long_match = (pulses == scp_pkg::PULSES_LONG)
        && (shift_in[scp_pkg::LONG_RW_POS] != scp_pkg::RW_READ)
        && (shift_in[scp_pkg::LONG_ADDR_LSB +: scp_pkg::ADDR_W]
            == st_q);
    assign short_match = (pulses == scp_pkg::PULSES_SHORT)
        && (shift_in[scp_pkg::SHORT_RW_POS] != scp_pkg::RW_READ)
        && (shift_in[scp_pkg::SHORT_ADDR_LSB +: scp_pkg::ADDR_W]
            == st_q);
    assign read_match = (pulses == scp_pkg::READ_CMP_PULSE)
        && (shift_in[scp_pkg::SHORT_RW_POS] == scp_pkg::RW_READ)
        && (shift_in[scp_pkg::SHORT_ADDR_LSB +: scp_pkg::ADDR_W]
            == st_q);

    // Frame state
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= scp_pkg::DV_IDLE;
        end
        else if (fe_rise)
        begin
            if (oc_q)
            begin
                state <= scp_pkg::DV_OCTL;
            end
            else
            begin
                state <= scp_pkg::DV_GAIN;
            end
        end
        else if (fe_fall)
        begin
            state <= scp_pkg::DV_IDLE;
        end
        else if (ck_fall && state == scp_pkg::DV_GAIN && read_match)
        begin
            state <= scp_pkg::DV_READ;
        end
    end

    // Pulse counter and input shifter
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pulses   <= 5'h00;
            shift_in <= 16'h0000;
        end
        else if (fe_rise)
        begin
            pulses   <= 5'h00;
            shift_in <= 16'h0000;
        end
        else if (ck_rise && state != scp_pkg::DV_IDLE)
        begin
            if (pulses != 5'h1f)
            begin
                pulses <= pulses + 5'h01;
            end
            shift_in <= {shift_in[14:0], dt_q};
        end
    end

    // Setting register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            adj_code <= scp_pkg::CODE_RESET;
        end
        else if (fe_fall && state == scp_pkg::DV_GAIN && long_match)
        begin
            adj_code <= shift_in[scp_pkg::CODE_W-1:0];
        end
    end

    assign feedback_cap_code    = adj_code[scp_pkg::FB_CAP_LSB +: 2];
    assign conversion_time_code = adj_code[scp_pkg::CONV_TIME_LSB +: 2];
    assign post_gain_code       = adj_code[scp_pkg::POST_GAIN_LSB +: 4];

    // Analog output enable
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            analog_out_en <= 1'b0;
        end
        else if (fe_fall && state == scp_pkg::DV_OCTL)
        begin
            analog_out_en <= short_match;
        end
    end

    // Read-out driver
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            link.dev_data_o  <= 1'b0;
            link.dev_data_oe <= 1'b0;
            shift_out        <= 8'h00;
        end
        else if (fe_fall || fe_rise)
        begin
            link.dev_data_o  <= 1'b0;
            link.dev_data_oe <= 1'b0;
        end
        else if (ck_fall && state == scp_pkg::DV_GAIN && read_match)
        begin
            link.dev_data_oe <= 1'b1;
            link.dev_data_o  <= adj_code[scp_pkg::CODE_W-1];
            shift_out        <= {adj_code[6:0], 1'b0};
        end
        else if (ck_fall && state == scp_pkg::DV_READ)
        begin
            if (pulses <= scp_pkg::READ_LAST_PULSE)
            begin
                link.dev_data_o <= shift_out[7];
                shift_out       <= {shift_out[6:0], 1'b0};
            end
            else
            begin
                link.dev_data_o <= 1'b0;
            end
        end
    end
endmodule : scp_dev

// ---- scp_host.sv ----
module scp_host #(
    parameter int AW = 8
) (
    input  wire logic          core_clk,
    input  wire logic          resetn,
    scp_if.host                link,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr
);
    logic                     cfg_octl;
    logic                     busy;
    logic [7:0]               rdata;
    logic [7:0]               rx;
    logic [15:0]              tx;
    logic                     reading;
    logic [4:0]               total;
    logic [4:0]               pulses;
    logic [7:0]               hc;
    logic                     tick;
    logic                     dl_m;
    logic                     dl_q;
    logic                     wr_done;
    logic                     start;
    logic [7:0]               off;
    scp_pkg::scp_host_state_e state;

    assign off     = 8'(paddr);
    assign wr_done = psel & penable & pready & pwrite;
    assign start   = wr_done && off == scp_pkg::REG_CMD && !busy;
    assign tick    = hc == scp_pkg::SCLK_HALF_CYC - 8'h01;
    assign busy    = state != scp_pkg::HS_IDLE;

    // APB answer, one wait-free access phase
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pready  <= 1'b1;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (!pwrite && off == scp_pkg::REG_CFG)
            begin
                prdata[scp_pkg::CFG_OCTL_POS] <= cfg_octl;
            end
            else if (!pwrite && off == scp_pkg::REG_STATUS)
            begin
                prdata[scp_pkg::STAT_BUSY_POS] <= busy;
                prdata[scp_pkg::STAT_RDATA_LSB +: 8] <= rdata;
            end
            else if (off == scp_pkg::REG_CMD)
            begin
                pslverr <= pwrite & busy;
            end
            else if (off != scp_pkg::REG_CFG && off != scp_pkg::REG_STATUS)
            begin
                pslverr <= 1'b1;
            end
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Mode level register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_octl <= 1'b0;
        end
        else if (wr_done && off == scp_pkg::REG_CFG)
        begin
            cfg_octl <= pwdata[scp_pkg::CFG_OCTL_POS];
        end
    end

    // Data line synchroniser
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dl_m <= 1'b1;
            dl_q <= 1'b1;
        end
        else
        begin
            dl_m <= link.data_line;
            dl_q <= dl_m;
        end
    end

    // Frame sequencer
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state             <= scp_pkg::HS_IDLE;
            hc                <= 8'h00;
            pulses            <= 5'h00;
            total             <= 5'h00;
            reading           <= 1'b0;
            tx                <= 16'h0000;
            rx                <= 8'h00;
            rdata             <= 8'h00;
            link.frame_enable <= 1'b0;
            link.sclk         <= 1'b0;
            link.out_ctrl     <= 1'b0;
            link.host_data_o  <= 1'b0;
            link.host_data_oe <= 1'b0;
        end
        else
        begin
            hc <= tick ? 8'h00 : hc + 8'h01;
            unique case (state)
                scp_pkg::HS_IDLE:
                begin
                    hc            <= 8'h00;
                    link.out_ctrl <= cfg_octl;
                    if (start)
                    begin
                        reading <= pwdata[scp_pkg::CMD_RW_POS];
                        total   <= (cfg_octl & ~pwdata[scp_pkg::CMD_RW_POS])
                                   ? scp_pkg::PULSES_SHORT
                                   : scp_pkg::PULSES_LONG;
                        tx      <= {pwdata[scp_pkg::CMD_RW_POS],
                                    pwdata[scp_pkg::CMD_ADDR_LSB +: 3],
                                    pwdata[11:0]};
                        pulses  <= 5'h00;
                        link.frame_enable <= 1'b1;
                        link.host_data_o  <= pwdata[scp_pkg::CMD_RW_POS];
                        link.host_data_oe <= 1'b1;
                        state   <= scp_pkg::HS_LOW;
                    end
                end
                scp_pkg::HS_LOW:
                begin
                    if (tick)
                    begin
                        link.sclk <= 1'b1;
                        pulses    <= pulses + 5'h01;
                        if (reading && pulses >= scp_pkg::READ_CMP_PULSE)
                        begin
                            rx <= {rx[6:0], dl_q};
                        end
                        state <= scp_pkg::HS_HIGH;
                    end
                end
                scp_pkg::HS_HIGH:
                begin
                    if (tick)
                    begin
                        link.sclk <= 1'b0;
                        tx        <= {tx[14:0], 1'b0};
                        link.host_data_o <= tx[14];
                        if (reading && pulses == scp_pkg::READ_CMP_PULSE)
                        begin
                            link.host_data_oe <= 1'b0;
                        end
                        state <= (pulses == total) ? scp_pkg::HS_TAIL
                                                   : scp_pkg::HS_LOW;
                    end
                end
                scp_pkg::HS_TAIL:
                begin
                    if (tick)
                    begin
                        link.frame_enable <= 1'b0;
                        link.host_data_o  <= 1'b0;
                        link.host_data_oe <= 1'b0;
                        if (reading)
                        begin
                            rdata <= rx;
                        end
                        state <= scp_pkg::HS_GAP;
                    end
                end
                scp_pkg::HS_GAP:
                begin
                    if (tick)
                    begin
                        state <= scp_pkg::HS_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : scp_host

// ---- scp_if.sv ----
interface scp_if;
    logic frame_enable;
    logic sclk;
    logic out_ctrl;
    logic host_data_o;
    logic host_data_oe;
    logic dev_data_o;
    logic dev_data_oe;
    logic data_line;

    // Shared data wire with pull-up
    assign data_line = dev_data_oe ? dev_data_o :
                       (host_data_oe ? host_data_o : 1'b1);

    modport dev (
        input  frame_enable,
        input  sclk,
        input  out_ctrl,
        input  data_line,
        output dev_data_o,
        output dev_data_oe
    );

    modport host (
        output frame_enable,
        output sclk,
        output out_ctrl,
        output host_data_o,
        output host_data_oe,
        input  data_line
    );
endinterface : scp_if

// ---- scp_link_sva.sv ----
module scp_link_sva (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic frame_enable,
    input wire logic sclk,
    input wire logic out_ctrl,
    input wire logic host_data_o,
    input wire logic host_data_oe,
    input wire logic dev_data_oe
);
    logic [4:0] n_rise;
    logic [7:0] n_hold;
    logic       sclk_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // Rising clock edges within the frame
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            n_rise <= 5'h00;
        else if (!frame_enable)
            n_rise <= 5'h00;
        else if (sclk && !sclk_q)
            n_rise <= n_rise + 5'h01;
    end

    // Cycles since the last clock level change
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_q <= 1'b0;
            n_hold <= 8'h00;
        end
        else
        begin
            sclk_q <= sclk;
            n_hold <= (sclk != sclk_q) ? 8'h01 : n_hold + 8'h01;
        end
    end

    a_clk_in_frame: assert property (sclk |-> frame_enable)
        else $error("link clock high outside a frame");
    a_data_stable_rise: assert property (
        $rose(sclk) && host_data_oe |-> $stable(host_data_o))
        else $error("host data moved at clock rise");
    a_start_drives: assert property (
        $rose(frame_enable) |-> host_data_oe)
        else $error("frame started without host drive");
    a_read_release: assert property (
        $fell(frame_enable) |-> ##[1:6] !dev_data_oe)
        else $error("device kept data after frame end");
    a_no_contention: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive data");
    a_tail_low: assert property (
        $fell(frame_enable) |-> !sclk && !$past(sclk))
        else $error("frame closed with clock high");
    a_pulse_count: assert property (
        $fell(frame_enable)
        |-> n_rise == 5'h10 || (out_ctrl && n_rise == 5'h08))
        else $error("wrong pulse count in frame");
    a_half_period: assert property (
        $fell(sclk) |-> n_hold == scp_pkg::SCLK_HALF_CYC)
        else $error("clock high phase wrong length");
    a_drive_eighth: assert property (
        $rose(dev_data_oe) |-> n_rise == 5'h08)
        else $error("device drove before eighth pulse");

    c_read_drive: cover property ($rose(dev_data_oe));
    c_short_frame: cover property ($fell(frame_enable) && out_ctrl);
    c_long_frame: cover property ($fell(frame_enable) && !out_ctrl);
endmodule : scp_link_sva

// ---- scp_pkg.sv ----
package scp_pkg;
    localparam int          ADDR_W          = 3;
    localparam int          CODE_W          = 8;
    localparam int          FRAME_W         = 16;
    localparam logic [4:0]  PULSES_LONG     = 5'h10;
    localparam logic [4:0]  PULSES_SHORT    = 5'h08;
    localparam logic [4:0]  READ_CMP_PULSE  = 5'h08;
    localparam logic [4:0]  READ_LAST_PULSE = 5'h0f;
    localparam int          LONG_RW_POS     = 15;
    localparam int          LONG_ADDR_LSB   = 12;
    localparam int          SHORT_RW_POS    = 7;
    localparam int          SHORT_ADDR_LSB  = 4;
    localparam int          POST_GAIN_LSB   = 0;
    localparam int          CONV_TIME_LSB   = 4;
    localparam int          FB_CAP_LSB      = 6;
    localparam logic        RW_READ         = 1'b1;
    localparam logic [7:0]  CODE_RESET      = 8'h00;
    localparam int          CORE_CLK_NS     = 4;
    localparam int          SCLK_HALF_NS    = 500;
    localparam logic [7:0]  SCLK_HALF_CYC   =
        8'((SCLK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
    localparam logic [7:0]  REG_CFG         = 8'h00;
    localparam logic [7:0]  REG_CMD         = 8'h04;
    localparam logic [7:0]  REG_STATUS      = 8'h08;
    localparam int          CFG_OCTL_POS    = 0;
    localparam int          CMD_RW_POS      = 16;
    localparam int          CMD_ADDR_LSB    = 12;
    localparam int          STAT_BUSY_POS   = 0;
    localparam int          STAT_RDATA_LSB  = 8;

    typedef enum logic [1:0] {
        DV_IDLE,
        DV_GAIN,
        DV_OCTL,
        DV_READ
    } scp_dev_state_e;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_LOW,
        HS_HIGH,
        HS_TAIL,
        HS_GAP
    } scp_host_state_e;
endpackage : scp_pkg

// ---- tb_sensor_cfg_serial_port.sv ----
module tb_sensor_cfg_serial_port;
    timeunit 1ns;
    timeprecision 1ps;

    `define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin \
        n_errors++; $display("wrong value at %0t: %s", $time, m); end end

    localparam int HALF = 20;
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        err;
    logic [1:0]  fb;
    logic [1:0]  ct;
    logic [3:0]  pg;
    logic        en;
    logic        en2;
    int          n_errors = 0;
    int          checks   = 0;

    scp_if link ();
    scp_if link2 ();

    scp_host scp_host_i (.core_clk(core_clk), .resetn(resetn), .link(link),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    scp_dev scp_dev_i (.core_clk(core_clk), .resetn(resetn), .link(link),
        .strap_addr(3'h5), .feedback_cap_code(fb),
        .conversion_time_code(ct), .post_gain_code(pg),
        .analog_out_en(en));
    scp_dev scp_dev_fault_i (.core_clk(core_clk), .resetn(resetn),
        .link(link2), .strap_addr(3'h2), .feedback_cap_code(),
        .conversion_time_code(), .post_gain_code(), .analog_out_en(en2));
    scp_link_sva scp_link_sva_i (.core_clk(core_clk), .resetn(resetn),
        .frame_enable(link.frame_enable), .sclk(link.sclk),
        .out_ctrl(link.out_ctrl), .host_data_o(link.host_data_o),
        .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe));

    always #2 core_clk = ~core_clk;

    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic idle_wait;
        int i;
        i = 0;
        do
        begin
            apb(1'b0, scp_pkg::REG_STATUS, 32'h0);
            i++;
        end
        while (rd[scp_pkg::STAT_BUSY_POS] !== 1'b0 && i < 4000);
        `CHK(rd[0], 1'b0, "busy stuck")
    endtask : idle_wait

    function automatic logic [31:0] word(input logic rw, input logic [2:0] a,
                                         input logic [11:0] s);
        return (32'(rw) << 16) | (32'(a) << 12) | 32'(s);
    endfunction : word

    task automatic cmd(input logic rw, input logic [2:0] a,
                       input logic [11:0] s);
        apb(1'b1, scp_pkg::REG_CMD, word(rw, a, s));
        idle_wait();
    endtask : cmd

    task automatic bang(input logic [7:0] b, input int n);
        int i;
        @(posedge core_clk);
        link2.frame_enable <= 1'b1;
        link2.host_data_oe <= 1'b1;
        link2.host_data_o  <= b[7];
        for (i = 0; i < n; i++)
        begin
            repeat (HALF) @(posedge core_clk);
            link2.sclk <= 1'b1;
            repeat (HALF) @(posedge core_clk);
            link2.sclk <= 1'b0;
            link2.host_data_o <= (i < 7) ? b[6 - i] : ~link2.host_data_o;
        end
        repeat (HALF) @(posedge core_clk);
        link2.frame_enable <= 1'b0;
        link2.host_data_oe <= 1'b0;
        repeat (HALF) @(posedge core_clk);
    endtask : bang

    task automatic t_apb;
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(err, 1'b1, "unmapped read not refused")
        `CHK(rd, 32'h0, "unmapped read data")
    endtask : t_apb

    task automatic t_gain;
        apb(1'b1, scp_pkg::REG_CFG, 32'h0);
        apb(1'b1, scp_pkg::REG_CMD, word(1'b0, 3'h5, 12'hab7));
        apb(1'b1, scp_pkg::REG_CMD, word(1'b0, 3'h5, 12'h000));
        `CHK(err, 1'b1, "write while busy accepted")
        idle_wait();
        `CHK({fb, ct, pg}, 8'hb7, "setting not loaded")
        cmd(1'b0, 3'h4, 12'h000);
        `CHK({fb, ct, pg}, 8'hb7, "foreign setting loaded")
    endtask : t_gain

    task automatic t_read;
        cmd(1'b1, 3'h5, 12'h000);
        `CHK(rd[15:8], 8'hb7, "read code")
        cmd(1'b1, 3'h3, 12'h000);
        `CHK(rd[15:8], 8'hff, "foreign read answered")
    endtask : t_read

    task automatic t_octl;
        apb(1'b1, scp_pkg::REG_CFG, 32'h1);
        apb(1'b0, scp_pkg::REG_CFG, 32'h0);
        `CHK(rd, 32'h1, "mode level readback")
        cmd(1'b0, 3'h5, 12'h000);
        `CHK(en, 1'b1, "output not enabled")
        cmd(1'b0, 3'h5, 12'h000);
        `CHK(en, 1'b1, "repeated frame refused")
        cmd(1'b0, 3'h2, 12'h000);
        `CHK(en, 1'b0, "mismatch kept output")
        apb(1'b1, scp_pkg::REG_CFG, 32'h0);
    endtask : t_octl

    task automatic t_fault;
        bang(8'h20, 8);
        `CHK(en2, 1'b1, "eight pulses not enabled")
        bang(8'h20, 7);
        `CHK(en2, 1'b0, "seven pulses kept output")
        bang(8'h20, 8);
        `CHK(en2, 1'b1, "eight pulses not re-enabled")
        bang(8'h20, 9);
        `CHK(en2, 1'b0, "nine pulses kept output")
    endtask : t_fault

    initial
    begin
        link2.frame_enable = 1'b0;
        link2.sclk         = 1'b0;
        link2.out_ctrl     = 1'b1;
        link2.host_data_o  = 1'b0;
        link2.host_data_oe = 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        t_apb();
        t_gain();
        t_read();
        t_octl();
        t_fault();
        conclude();
    end

    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule : tb_sensor_cfg_serial_port
